// [rtl/slpctl_pkg.sv]
/*
 * Package of the sleep mode control block: opcode fields, operand
 * layout, pipeline depth and shared carrier types.
 * Assumes a single core clock and synchronous active-high reset.
 */
package slpctl_pkg;

    // ==========================================================
    // Instruction decode
    // ==========================================================
    localparam logic [31:0] SLP_OPC_MASK   = 32'hffbf_f03f;
    localparam logic [31:0] SLP_OPC_MATCH  = 32'h212f_003f;
    localparam int          SLP_MODE_BIT   = 22; // 1 = immediate form
    localparam int          SLP_OPND_LSB   = 6;
    localparam int          SLP_OPND_W     = 6;
    localparam int          SLP_EN_W       = 2;  // Enable bits used

    // ==========================================================
    // Pipeline
    // ==========================================================
    localparam int          SLP_PIPE_DEPTH = 4;  // Stages after decode
    localparam logic [2:0]  SLP_CNT_W0     = 3'h0;
    localparam logic [1:0]  SLP_OPND_NONE  = 2'h0;
    localparam logic [1:0]  SLP_OPND_LO    = 2'h1;
    localparam logic [1:0]  SLP_OPND_HI    = 2'h2;
    localparam logic [1:0]  SLP_OPND_BOTH  = 2'h3;

    typedef enum logic [1:0] {
        SLP_RUN,
        SLP_DRAIN,
        SLP_DOZE
    } slpctl_state_e;

    // Interrupt enable pair
    typedef struct packed {
        logic hi;
        logic lo;
    } slpctl_ien_s;

    // Host debug requests
    typedef struct packed {
        logic halt;
        logic restart;
        logic step_mode;
    } slpctl_host_s;

endpackage

// [rtl/slpctl_decode.sv]
/*
 * Decoder for the doze instruction: recognises both operand forms
 * and yields the two enable bits that the operand carries.
 * Assumes the register operand value is supplied alongside.
 */
`timescale 1ns/1ps

module slpctl_decode (
    input  wire logic [31:0] i_instr,
    input  wire logic [31:0] i_reg_val,
    output logic             o_is_doze,
    output logic [1:0]       o_en_val
);
    import slpctl_pkg::*;

    logic [SLP_OPND_W-1:0] opnd;

    // ==========================================================
    // Match and operand select
    // ==========================================================
    // Immediate form takes the field, register form the value;
    // only the bottom two bits matter, upper four ignored
    always_comb begin
        o_is_doze = ((i_instr & SLP_OPC_MASK) == SLP_OPC_MATCH);
        if (i_instr[SLP_MODE_BIT]) begin
            opnd = i_instr[SLP_OPND_LSB +: SLP_OPND_W];
        end else begin
            opnd = i_reg_val[SLP_OPND_W-1:0];
        end
        o_en_val = opnd[SLP_EN_W-1:0]; // RULE1 RULE9
    end

endmodule

// [rtl/slpctl_top.sv]
/*
 * Sleep mode control: carries the doze instruction from decode
 * through drain, doze and wake, owning the doze flag, interrupt
 * enables and the held program counter.
 * Assumes the surrounding pipeline reports stage occupancy and
 * kills, and that interrupt, halt and restart are clock-synchronous.
 */
`timescale 1ns/1ps

// Behaviour
// (RULE1) Decode immediate and register doze forms
// (RULE2) Only doze flag changes; ZNCV untouched
// (RULE3) Stall fetch, drain pipe, then set flag
// (RULE4) Stay stalled until interrupt or restart
// (RULE5) Freeze pipe, disable memories, gate clocks
// (RULE6) Host access and halt keep working
// (RULE7) Host cannot clear flag; halt then restart
// (RULE8) PC holds address after doze instruction
// (RULE9) Only low two operand bits used
// (RULE10) Operand values set interrupt enables
// (RULE11) Interrupt wake clears flag, kills stage1
// (RULE12) Restart after halt clears flag
// (RULE13) Single step makes doze a no-op
// (RULE14) Flag-write enables apply at stage four
// (RULE15) Software pairs enable write with doze
// (RULE16) Three no-ops after halt-setting write
// (RULE17) Delay-slot doze sleeps at branch target
// (RULE18) Killed delay-slot doze is ignored
// (RULE19) Older cores: placement limits on doze
// (RULE20) Older cores: align write-doze pair
// (RULE21) Wake only on interrupts enabled now
module slpctl_top (
    input  wire logic                 I_CLK,
    input  wire logic                 I_RESET,
    input  wire logic [31:0]          i_dec_instr,
    input  wire logic                 i_dec_valid,
    input  wire logic                 i_dec_killed,
    input  wire logic [31:0]          i_dec_reg_val,
    input  wire logic [31:0]          i_dec_next_pc,
    input  wire logic                 i_dec_in_dslot,
    input  wire logic [31:0]          i_branch_target,
    input  wire logic [3:0]           i_stage_busy,
    input  wire logic                 i_flag_wr,
    input  wire slpctl_pkg::slpctl_ien_s i_flag_wr_ien,
    input  wire logic                 i_irq_lo,
    input  wire logic                 i_irq_hi,
    input  wire slpctl_pkg::slpctl_host_s i_host,
    input  wire logic                 i_clk_gate_cfg,
    output logic                      o_fetch_stall,
    output logic                      o_pipe_hold,
    output logic                      o_mem_disable,
    output logic                      o_clk_gate_off,
    output logic                      o_kill_stage1,
    output logic                      o_irq_take,
    output logic                      o_doze_flag,
    output slpctl_pkg::slpctl_ien_s   o_ien,
    output logic [31:0]               o_doze_pc,
    output logic                      o_halted
);
    import slpctl_pkg::*;

    // ==========================================================
    // Decode
    // ==========================================================
    logic       dec_is_doze;
    logic [1:0] dec_en_val;

    slpctl_decode u_dec (
        .i_instr   (i_dec_instr),
        .i_reg_val (i_dec_reg_val),
        .o_is_doze (dec_is_doze),
        .o_en_val  (dec_en_val)
    );

    // ==========================================================
    // State
    // ==========================================================
    slpctl_state_e state_r, state_nxt;
    logic          flag_r, flag_nxt;
    slpctl_ien_s   ien_r, ien_nxt;
    logic [1:0]    pend_en_r, pend_en_nxt;
    logic [31:0]   pc_r, pc_nxt;
    logic          halt_r, halt_nxt;
    logic          stall_r, stall_nxt;
    logic          hold_r, hold_nxt;
    logic          mem_off_r, mem_off_nxt;
    logic          gate_r, gate_nxt;
    logic          kill_r, kill_nxt;
    logic          take_r, take_nxt;

    logic          doze_start;
    logic          irq_wake;
    logic          irq_go;
    logic          enter_doze;
    slpctl_ien_s   ien_doze;

    // A doze only starts from a live, executed slot and not while
    // stepping, where every step is itself a restart
    assign doze_start = i_dec_valid && dec_is_doze && !i_dec_killed
                        && !i_host.step_mode && !halt_r; // RULE13 RULE18

    // Enables as they stand after the doze operand has applied
    always_comb begin
        ien_doze = ien_r;
        case (pend_en_r) // RULE10
            SLP_OPND_LO:   ien_doze = '{hi: 1'b0, lo: 1'b1};
            SLP_OPND_HI:   ien_doze = '{hi: 1'b1, lo: 1'b0};
            SLP_OPND_BOTH: ien_doze = '{hi: 1'b1, lo: 1'b1};
            default:       ien_doze = ien_r;
        endcase
    end

    assign irq_wake = (i_irq_lo && ien_doze.lo)
                      || (i_irq_hi && ien_doze.hi); // RULE21

    // Drain ends once every later stage is empty and no flag
    // write is still committing
    assign enter_doze = (state_r == SLP_DRAIN) && (i_stage_busy == 4'h0)
                        && !i_flag_wr; // RULE3 RULE14

    // Interrupts are ignored while the host holds or asks halt
    assign irq_go = (state_r == SLP_DOZE) && irq_wake
                    && !halt_r && !i_host.halt; // RULE4 RULE11

    // ==========================================================
    // Host halt next value
    // ==========================================================
    // Halt wins over a restart in the same cycle; the host keeps
    // this path in every state, dozing included
    always_comb begin
        halt_nxt = halt_r;
        if (i_host.halt) begin
            halt_nxt = 1'b1; // RULE6
        end else if (i_host.restart && halt_r) begin
            halt_nxt = 1'b0; // RULE12
        end
    end

    // ==========================================================
    // Interrupt enable next value
    // ==========================================================
    // A write committing at stage four lands at once; doze entry
    // never meets one, as drain waits for the write to pass
    always_comb begin
        ien_nxt = ien_r;
        if (i_flag_wr) begin
            ien_nxt = i_flag_wr_ien; // RULE14
        end else if (enter_doze) begin
            ien_nxt = ien_doze; // RULE10
        end
    end

    // ==========================================================
    // Sequencer next values
    // ==========================================================
    // Drain waits for every later stage to empty before the flag
    // rises, so older flag writes land first
    always_comb begin
        state_nxt   = state_r;
        flag_nxt    = flag_r;
        pend_en_nxt = pend_en_r;
        pc_nxt      = pc_r;

        // Host writes never touch the flag; only a restart out of
        // halt clears it, the host's one way to wake the core
        if (i_host.restart && halt_r && !i_host.halt
            && state_r == SLP_DOZE) begin
            flag_nxt  = 1'b0; // RULE7 RULE12
            state_nxt = SLP_RUN;
        end

        case (state_r)
            SLP_RUN: begin
                if (doze_start) begin
                    state_nxt   = SLP_DRAIN; // RULE3
                    pend_en_nxt = dec_en_val;
                    if (i_dec_in_dslot) begin
                        pc_nxt = i_branch_target; // RULE17
                    end else begin
                        pc_nxt = i_dec_next_pc; // RULE8
                    end
                end
            end
            SLP_DRAIN: begin
                if (enter_doze) begin
                    state_nxt   = SLP_DOZE;
                    flag_nxt    = 1'b1; // RULE2 RULE3
                    pend_en_nxt = SLP_OPND_NONE;
                end
            end
            SLP_DOZE: begin
                // Pipe stays frozen here until a wake event
                if (irq_go) begin
                    state_nxt = SLP_RUN; // RULE4
                    flag_nxt  = 1'b0; // RULE11
                end
            end
            default: begin
                state_nxt = SLP_RUN;
            end
        endcase
    end

    // ==========================================================
    // Output next values
    // ==========================================================
    // Levels follow the next state, so each pin changes on the
    // same edge as the state that it reports
    always_comb begin
        stall_nxt   = 1'b0;
        hold_nxt    = 1'b0;
        mem_off_nxt = 1'b0;
        gate_nxt    = 1'b0;
        case (state_nxt)
            SLP_DRAIN: begin
                stall_nxt = 1'b1; // RULE3
            end
            SLP_DOZE: begin
                stall_nxt   = 1'b1; // RULE4
                hold_nxt    = 1'b1; // RULE5
                mem_off_nxt = 1'b1; // RULE5
                // Gating only where the option is built in
                gate_nxt    = i_clk_gate_cfg; // RULE5
            end
            default: begin
                stall_nxt = 1'b0;
            end
        endcase
        // One-cycle pulses on the edge that leaves doze
        kill_nxt = irq_go; // RULE11
        take_nxt = irq_go; // RULE11
    end

    // ==========================================================
    // Halt register
    // ==========================================================
    // Host halt state, cleared by reset or by a restart while halted
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            halt_r <= 1'b0;
        end else begin
            halt_r <= halt_nxt;
        end
    end

    // ==========================================================
    // Interrupt enable register
    // ==========================================================
    // Both levels start disabled
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            ien_r <= '0;
        end else begin
            ien_r <= ien_nxt;
        end
    end

    // ==========================================================
    // Sequencer registers
    // ==========================================================
    // Synchronous reset; the core starts running, not dozing
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            state_r   <= SLP_RUN;
            flag_r    <= 1'b0;
            pend_en_r <= SLP_OPND_NONE;
            pc_r      <= 32'h0000_0000;
        end else begin
            state_r   <= state_nxt;
            flag_r    <= flag_nxt;
            pend_en_r <= pend_en_nxt;
            pc_r      <= pc_nxt;
        end
    end

    // ==========================================================
    // Output registers
    // ==========================================================
    // Kept apart so the pins never see a combinational path
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            stall_r   <= 1'b0;
            hold_r    <= 1'b0;
            mem_off_r <= 1'b0;
            gate_r    <= 1'b0;
            kill_r    <= 1'b0;
            take_r    <= 1'b0;
        end else begin
            stall_r   <= stall_nxt;
            hold_r    <= hold_nxt;
            mem_off_r <= mem_off_nxt;
            gate_r    <= gate_nxt;
            kill_r    <= kill_nxt;
            take_r    <= take_nxt;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // Every pin is a register, no logic after the flops
    assign o_fetch_stall  = stall_r;
    assign o_pipe_hold    = hold_r;
    assign o_mem_disable  = mem_off_r;
    assign o_clk_gate_off = gate_r;
    assign o_kill_stage1  = kill_r;
    assign o_irq_take     = take_r;
    assign o_doze_flag    = flag_r;
    assign o_ien          = ien_r;
    assign o_doze_pc      = pc_r;
    assign o_halted       = halt_r;

endmodule

// [verification/slpctl_props.sv]
/* Checker: port-level relations of the sleep mode control block.
   Assumes it is bound onto every slpctl_top with all ports by name. */
`timescale 1ns/1ps
module slpctl_props
    import slpctl_pkg::*;
(
    input wire logic                     I_CLK,
    input wire logic                     I_RESET,
    input wire logic [31:0]              i_dec_instr,
    input wire logic                     i_dec_valid,
    input wire logic                     i_dec_killed,
    input wire logic [3:0]               i_stage_busy,
    input wire logic                     i_flag_wr,
    input wire logic                     i_irq_lo,
    input wire logic                     i_irq_hi,
    input wire slpctl_pkg::slpctl_host_s i_host,
    input wire logic                     o_fetch_stall,
    input wire logic                     o_pipe_hold,
    input wire logic                     o_mem_disable,
    input wire logic                     o_clk_gate_off,
    input wire logic                     o_kill_stage1,
    input wire logic                     o_irq_take,
    input wire logic                     o_doze_flag,
    input wire slpctl_pkg::slpctl_ien_s  o_ien,
    input wire logic [31:0]              o_doze_pc,
    input wire logic                     o_halted
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // ==========================================================
    // Helpers
    // ==========================================================
    // A doze accepted at decode; one at a time, so stall masks it
    logic tk;
    logic wk;
    assign tk = i_dec_valid && !i_dec_killed && !i_host.step_mode &&
        ((i_dec_instr & SLP_OPC_MASK) == SLP_OPC_MATCH) &&
        !o_halted && !o_fetch_stall;
    assign wk = (i_irq_lo && o_ien.lo) || (i_irq_hi && o_ien.hi);
    // ==========================================================
    // Properties
    // ==========================================================
    stall_on_take_a: assert property (tk |=> o_fetch_stall)
        else $error("fetch not stalled after doze");
    no_take_a: assert property (i_dec_valid && !o_fetch_stall &&
        (i_dec_killed || i_host.step_mode) |=> !o_fetch_stall)
        else $error("ignored doze stalled fetch");
    flag_drain_a: assert property (o_fetch_stall && !o_doze_flag &&
        !o_halted && i_stage_busy == 4'h0 && !i_flag_wr
        |=> ##[0:1] o_doze_flag)
        else $error("flag not set after drain");
    flag_cause_a: assert property ($rose(o_doze_flag) |->
        $past(o_fetch_stall) && $past(i_stage_busy) == 4'h0
        && !$past(i_flag_wr))
        else $error("flag set before drain");
    doze_hold_a: assert property (o_doze_flag |->
        o_fetch_stall && o_pipe_hold && o_mem_disable)
        else $error("doze without hold");
    gate_only_a: assert property (o_clk_gate_off |-> o_doze_flag)
        else $error("clock gated outside doze");
    host_clear_a: assert property ($fell(o_doze_flag) |->
        o_irq_take || $past(i_host.restart))
        else $error("flag cleared without wake");
    irq_wake_a: assert property (o_doze_flag && !o_halted && wk
        && !i_host.halt |=> o_irq_take && o_kill_stage1 && !o_doze_flag)
        else $error("enabled interrupt did not wake");
    take_pulse_a: assert property (o_irq_take |=> !o_irq_take)
        else $error("wake pulse too long");
    pc_steady_a: assert property (o_doze_flag && $past(o_doze_flag)
        |-> $stable(o_doze_pc))
        else $error("held pc moved in doze");
endmodule

bind slpctl_top slpctl_props u_props (.*);

// [verification/slpctl_hostm.sv]
/* Partner: host debug interface and interrupt sources.
   Assumes the bench calls its tasks; all changes land on falling edges. */
`timescale 1ns/1ps
module slpctl_hostm
    import slpctl_pkg::*;
(
    input  wire logic          I_CLK,
    output slpctl_host_s       o_host,
    output logic               o_irq_lo,
    output logic               o_irq_hi
);
    // ==========================================================
    // Idle state
    // ==========================================================
    initial begin
        o_host = '0;
        o_irq_lo = 1'b0;
        o_irq_hi = 1'b0;
    end
    // Levels stay up until serviced, like a real source
    task automatic irq(input logic lo, input logic hi);
        @(negedge I_CLK);
        o_irq_lo = lo;
        o_irq_hi = hi;
    endtask
    // Host wakes only by halt then restart, never by a flag write
    task automatic pulse(input logic h, input logic r);
        @(negedge I_CLK);
        o_host.halt = h;
        o_host.restart = r;
        @(negedge I_CLK);
        o_host.halt = 1'b0;
        o_host.restart = 1'b0;
    endtask
    task automatic step(input logic s);
        @(negedge I_CLK);
        o_host.step_mode = s;
    endtask
endmodule

// [verification/tb.sv]
/* Bench for slpctl_top: doze entry, operands, wake paths, halt.
   Assumes the checker is bound in and the partner drives host/irq. */
`timescale 1ns/1ps
module tb;
    import slpctl_pkg::*;
    localparam logic [31:0] OP_IMM = 32'h216f_003f;
    localparam logic [31:0] OP_REG = 32'h212f_003f;
    logic I_CLK = 1'b0, I_RESET = 1'b1;
    logic [31:0] i_dec_instr = '0, i_dec_reg_val = '0, o_doze_pc;
    logic [31:0] i_dec_next_pc = 32'h0000_0100;
    logic [31:0] i_branch_target = 32'h0000_0200;
    logic i_dec_valid = 1'b0, i_dec_killed = 1'b0, i_dec_in_dslot = 1'b0;
    logic [3:0] i_stage_busy = 4'h0;
    logic i_flag_wr = 1'b0, i_clk_gate_cfg = 1'b1, i_irq_lo, i_irq_hi;
    slpctl_ien_s i_flag_wr_ien = '0, o_ien;
    slpctl_host_s i_host;
    logic o_fetch_stall, o_pipe_hold, o_mem_disable, o_clk_gate_off;
    logic o_kill_stage1, o_irq_take, o_doze_flag, o_halted;
    int fail_count = 0, comparisons = 0, cyc = 0;
    slpctl_top dut (.*);
    slpctl_hostm hm (.I_CLK(I_CLK), .o_host(i_host),
        .o_irq_lo(i_irq_lo), .o_irq_hi(i_irq_hi));
    always #5 I_CLK = ~I_CLK;
    // Hang guard: the whole sequence needs about 110 cycles
    always @(posedge I_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    // Doze at decode with stage 1 busy, then let the pipe empty
    task automatic enter(input logic [31:0] ins, input logic [31:0] rv,
                         input logic kd, input logic ds);
        @(negedge I_CLK);
        i_dec_instr = ins;
        i_dec_reg_val = rv;
        i_dec_killed = kd;
        i_dec_in_dslot = ds;
        i_dec_valid = 1'b1;
        i_stage_busy = 4'h1;
        @(negedge I_CLK);
        i_dec_valid = 1'b0;
        @(negedge I_CLK);
        chk("flag_early", 0, o_doze_flag);
        i_stage_busy = 4'h0;
        repeat (2) @(negedge I_CLK);
    endtask
    task automatic wake(input logic lo, input logic hi);
        logic got;
        logic kl;
        got = 1'b0;
        kl = 1'b0;
        hm.irq(lo, hi);
        repeat (4) @(negedge I_CLK) begin
            if (o_irq_take === 1'b1) got = 1'b1;
            if (o_kill_stage1 === 1'b1) kl = 1'b1;
        end
        hm.irq(1'b0, 1'b0);
        chk("irq_take", 1, got);
        chk("kill_stage1", 1, kl);
        chk("flag_wake", 0, o_doze_flag);
        chk("stall_wake", 0, o_fetch_stall);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_imm();
        enter(OP_IMM | 32'h0000_0fc0, 0, 1'b0, 1'b0);
        chk("flag", 1, o_doze_flag);
        chk("ien_3f", 3, o_ien);
        chk("pc", i_dec_next_pc, o_doze_pc);
        chk("mem_off", 1, o_mem_disable);
        chk("gate_off", 1, o_clk_gate_off);
        chk("hold", 1, o_pipe_hold);
        chk("stall", 1, o_fetch_stall);
        wake(1'b1, 1'b0);
    endtask
    // Operands 1, 2 then 0, which must keep the previous enables
    task automatic t_ops();
        logic [1:0] ex [3] = '{2'h1, 2'h2, 2'h2};
        for (int k = 0; k < 3; k++) begin
            enter(OP_REG, 32'hffff_fff0 | ((k + 1) % 3), 1'b0, 1'b0);
            chk("ien", ex[k], o_ien);
            hm.irq(ex[k] == 2'h2, ex[k] == 2'h1);
            repeat (3) @(negedge I_CLK);
            chk("masked", 1, o_doze_flag);
            wake(ex[k][0], ex[k][1]);
        end
    endtask
    task automatic t_halt();
        enter(OP_REG, 3, 1'b0, 1'b0);
        hm.pulse(1'b1, 1'b0);
        chk("halted", 1, o_halted);
        chk("flag_halt", 1, o_doze_flag);
        hm.pulse(1'b0, 1'b1);
        chk("flag_rst", 0, o_doze_flag);
        chk("halt_rst", 0, o_halted);
        chk("stall_rst", 0, o_fetch_stall);
    endtask
    task automatic t_dslot();
        enter(OP_IMM, 0, 1'b0, 1'b1);
        chk("pc_bta", i_branch_target, o_doze_pc);
        wake(1'b0, 1'b1);
    endtask
    task automatic t_nop();
        enter(OP_IMM, 0, 1'b1, 1'b0);
        chk("killed", 0, o_fetch_stall);
        hm.step(1'b1);
        enter(OP_IMM, 0, 1'b0, 1'b0);
        chk("step", 0, o_fetch_stall);
        hm.step(1'b0);
    endtask
    // A committing flag write holds the flag off a cycle and its
    // enables carry into doze; no gating without the option
    task automatic t_flag();
        i_clk_gate_cfg = 1'b0;
        @(negedge I_CLK);
        i_dec_instr = OP_IMM;
        i_dec_killed = 1'b0;
        i_dec_in_dslot = 1'b0;
        i_dec_valid = 1'b1;
        @(negedge I_CLK);
        i_dec_valid = 1'b0;
        i_flag_wr = 1'b1;
        i_flag_wr_ien = '{hi: 1'b0, lo: 1'b1};
        @(negedge I_CLK);
        i_flag_wr = 1'b0;
        chk("flag_wr", 0, o_doze_flag);
        chk("ien_wr", 1, o_ien);
        repeat (2) @(negedge I_CLK);
        chk("flag_after", 1, o_doze_flag);
        chk("gate_none", 0, o_clk_gate_off);
        chk("ien_keep", 1, o_ien);
        wake(1'b1, 1'b0);
        i_clk_gate_cfg = 1'b1;
    endtask
    // Stream never puts a halt set just before a doze; only t_flag puts a flag write there
    initial begin
        repeat (12) @(negedge I_CLK);
        I_RESET = 1'b0;
        t_imm();
        t_ops();
        t_halt();
        t_dslot();
        t_nop();
        t_flag();
        test_done();
    end
endmodule
